// ---- core/svwd_pkg.sv ----
package svwd_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_KHZ      = 10000;
    localparam int unsigned RST_DELAY_US     = 200;
    localparam int unsigned RST_CYCLES       = (RST_DELAY_US * SYS_CLK_KHZ) / 1000;
    localparam int unsigned WD_STD_MS        = 1600;
    localparam int unsigned WD_EXT_MS        = 6500;
    localparam int unsigned WD_CAP_MS        = 10;
    localparam int unsigned WD_STD_CYCLES    = WD_STD_MS * SYS_CLK_KHZ;
    localparam int unsigned WD_EXT_CYCLES    = WD_EXT_MS * SYS_CLK_KHZ;
    localparam int unsigned WD_CAP_CYCLES    = WD_CAP_MS * SYS_CLK_KHZ;
    localparam int unsigned CNT_W            = 32;

    // ------------------------------------------------------------------
    // Timeout select pin sensing codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  SEL_CAP          = 2'h0;
    localparam logic [1:0]  SEL_PULLUP       = 2'h1;
    localparam logic [1:0]  SEL_OPEN         = 2'h2;

    // ------------------------------------------------------------------
    // Reset values of synchronised inputs
    // ------------------------------------------------------------------
    localparam logic [0:0]  MR_SYNC_INIT     = 1'h1;
    localparam logic [0:0]  UV_SYNC_INIT     = 1'h1;
    localparam logic [0:0]  LOW_SYNC_INIT    = 1'h0;
    localparam logic [1:0]  SEL_SYNC_INIT    = 2'h0;

    typedef enum logic [1:0] {
        SVWD_WD_OFF,
        SVWD_WD_RUN,
        SVWD_WD_FLAG
    } svwd_wd_state_type;

endpackage

// ---- core/svwd_sync.sv ----
`timescale 1ns/100ps
module svwd_sync
    import svwd_pkg::*;
#(
    parameter int unsigned     W    = 1,
    parameter logic [W-1:0]    INIT = '0
) (
    input  wire logic          sys_clk,
    input  wire logic          resetn,
    input  wire logic [W-1:0]  d,
    output logic      [W-1:0]  q
);

    logic [W-1:0] meta;

    // The first stage is read only by the second stage.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ---- core/svwd_timer.sv ----
`timescale 1ns/100ps
module svwd_timer
    import svwd_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              clear,
    input  wire logic              run,
    input  wire logic [CNT_W-1:0]  limit,
    output logic      [CNT_W-1:0]  count,
    output logic                   done
);

    logic [CNT_W-1:0] next_count;

    // Clear has priority, so a restart never sees a stale expiry.
    always_comb begin
        next_count = count;
        if (clear) begin
            next_count = '0;
        end else if (run) begin
            next_count = count + CNT_W'(1);
        end
    end

    // Greater-or-equal, so a limit lowered mid-count still expires instead of wrapping.
    assign done = run && !clear && (count >= limit - CNT_W'(1));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule

// ---- core/svwd_core.sv ----
`timescale 1ns/100ps
module svwd_core
    import svwd_pkg::*;
#(
    parameter int unsigned  WD_STD_LIMIT = WD_STD_CYCLES,
    parameter int unsigned  WD_EXT_LIMIT = WD_EXT_CYCLES,
    parameter int unsigned  WD_CAP_LIMIT = WD_CAP_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        manual_rst_n,
    input  wire logic        manual_rst_float,
    input  wire logic        uv_detect,
    input  wire logic        wd_enable_strap,
    input  wire logic [1:0]  timeout_select_pin,
    input  wire logic        kick_in,
    output logic             sys_rst_n_out,
    output logic             sys_rst_n_oe_n,
    output logic             timeout_flag_n_out,
    output logic             timeout_flag_n_oe_n
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic                    mr_pin;
    logic                    mr_s;
    logic                    uv_s;
    logic                    en_s;
    logic                    kick_s;
    logic [1:0]              sel_s;

    // The pad pull-up wins whenever nobody drives the manual reset pin.
    assign mr_pin = manual_rst_float ? 1'b1 : manual_rst_n;

    svwd_sync #(.W(1), .INIT(MR_SYNC_INIT)) u_sync_mr (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       (mr_pin),
        .q       (mr_s)
    );

    // The comparator already applies hysteresis; only the level is carried here.
    svwd_sync #(.W(1), .INIT(UV_SYNC_INIT)) u_sync_uv (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       (uv_detect),
        .q       (uv_s)
    );

    svwd_sync #(.W(1), .INIT(LOW_SYNC_INIT)) u_sync_en (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       (wd_enable_strap),
        .q       (en_s)
    );

    svwd_sync #(.W(1), .INIT(LOW_SYNC_INIT)) u_sync_kick (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       (kick_in),
        .q       (kick_s)
    );

    svwd_sync #(.W(2), .INIT(SEL_SYNC_INIT)) u_sync_sel (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       (timeout_select_pin),
        .q       (sel_s)
    );

    // ------------------------------------------------------------------
    // System reset generation
    // ------------------------------------------------------------------
    logic                    rst_cause;
    logic                    sys_rst_n;
    logic                    next_sys_rst_n;
    logic [CNT_W-1:0]        rst_count;
    logic                    rst_done;

    assign rst_cause = !mr_s || uv_s;

    // Any active cause holds the counter at zero, so the delay always runs whole.
    svwd_timer u_rst_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clear   (rst_cause || sys_rst_n),
        .run     (!sys_rst_n && !rst_cause),
        .limit   (CNT_W'(RST_CYCLES)),
        .count   (rst_count),
        .done    (rst_done)
    );

    always_comb begin
        next_sys_rst_n = sys_rst_n;
        if (rst_cause) begin
            next_sys_rst_n = 1'b0;
        end else if (!sys_rst_n && rst_done) begin
            next_sys_rst_n = 1'b1;
        end
    end

    // Power-up starts in reset, so the delay applies after the supply is good.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sys_rst_n <= 1'b0;
        end else begin
            sys_rst_n <= next_sys_rst_n;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog window and timeout flag
    // ------------------------------------------------------------------
    svwd_wd_state_type       wd_state;
    svwd_wd_state_type       next_wd_state;
    logic                    timeout_flag_n;
    logic                    next_timeout_flag_n;
    logic                    kick_prev;
    logic                    kick_fall;
    logic [CNT_W-1:0]        wd_limit;
    logic [CNT_W-1:0]        wd_count;
    logic                    wd_done;
    logic [CNT_W-1:0]        flag_count;
    logic                    flag_done;
    logic                    wd_quiet;

    assign kick_fall = kick_prev && !kick_s;

    // Reset, a pending reset cause or a low strap parks the watchdog.
    assign wd_quiet = rst_cause || !sys_rst_n || !en_s;

    // An unknown select code falls back to the longest preset.
    always_comb begin
        if (sel_s == SEL_CAP) begin
            wd_limit = CNT_W'(WD_CAP_LIMIT);
        end else if (sel_s == SEL_PULLUP) begin
            wd_limit = CNT_W'(WD_STD_LIMIT);
        end else begin
            wd_limit = CNT_W'(WD_EXT_LIMIT);
        end
    end

    // Kicks only reach the counter in the running state.
    svwd_timer u_wd_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clear   ((wd_state != SVWD_WD_RUN) || kick_fall),
        .run     (wd_state == SVWD_WD_RUN),
        .limit   (wd_limit),
        .count   (wd_count),
        .done    (wd_done)
    );

    svwd_timer u_flag_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clear   (wd_state != SVWD_WD_FLAG),
        .run     (wd_state == SVWD_WD_FLAG),
        .limit   (CNT_W'(RST_CYCLES)),
        .count   (flag_count),
        .done    (flag_done)
    );

    always_comb begin
        next_wd_state = wd_state;
        if (wd_quiet) begin
            next_wd_state = SVWD_WD_OFF;
        end else begin
            case (wd_state)
                SVWD_WD_OFF: begin
                    next_wd_state = SVWD_WD_RUN;
                end
                SVWD_WD_RUN: begin
                    if (wd_done) begin
                        next_wd_state = SVWD_WD_FLAG;
                    end
                end
                SVWD_WD_FLAG: begin
                    if (flag_done) begin
                        next_wd_state = SVWD_WD_RUN;
                    end
                end
                default: begin
                    next_wd_state = SVWD_WD_OFF;
                end
            endcase
        end
        next_timeout_flag_n = (next_wd_state != SVWD_WD_FLAG);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wd_state       <= SVWD_WD_OFF;
            timeout_flag_n <= 1'b1;
            kick_prev      <= 1'b0;
        end else begin
            wd_state       <= next_wd_state;
            timeout_flag_n <= next_timeout_flag_n;
            kick_prev      <= kick_s;
        end
    end

    // ------------------------------------------------------------------
    // Open-drain outputs
    // ------------------------------------------------------------------
    // Both pins only ever pull low; the high level comes from board pull-ups.
    assign sys_rst_n_out       = 1'b0;
    assign sys_rst_n_oe_n      = sys_rst_n;
    assign timeout_flag_n_out  = 1'b0;
    assign timeout_flag_n_oe_n = timeout_flag_n;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [CNT_W-1:0]        hold_cnt;

    // Counts clean cycles spent in reset, independent of the reset timer.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hold_cnt <= '0;
        end else if (rst_cause || sys_rst_n) begin
            hold_cnt <= '0;
        end else begin
            hold_cnt <= hold_cnt + CNT_W'(1);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_mr_forces_reset: assert property (
        !mr_s |=> !sys_rst_n_oe_n)
        else $error("manual reset did not pull reset low");

    a_mr_pullup_default: assert property (
        manual_rst_float [*3] |-> mr_s)
        else $error("floating manual reset not read as high");

    a_uv_forces_reset: assert property (
        uv_s |=> !sys_rst_n_oe_n ##1 !sys_rst_n_oe_n)
        else $error("undervoltage did not hold reset low");

    a_release_after_delay: assert property (
        $rose(sys_rst_n_oe_n) |-> $past(hold_cnt) == CNT_W'(RST_CYCLES - 1))
        else $error("reset released at wrong delay");

    a_no_early_release: assert property (
        !sys_rst_n && (hold_cnt < CNT_W'(RST_CYCLES - 1)) |=> !sys_rst_n)
        else $error("reset released before delay elapsed");

    a_good_supply_first: assert property (
        $rose(sys_rst_n) |-> !$past(uv_s, 1) && $past(mr_s, 1) && !$past(uv_s, 2))
        else $error("reset released while supply was low");

    a_strap_disables_wd: assert property (
        !en_s |=> timeout_flag_n_oe_n && (wd_state == SVWD_WD_OFF))
        else $error("watchdog active with strap low");

    a_kick_ignored_flag: assert property (
        !timeout_flag_n && kick_fall && !wd_quiet
        && (flag_count < CNT_W'(RST_CYCLES - 1)) |=> !timeout_flag_n)
        else $error("kick cut the timeout flag short");

    a_kick_restarts_wd: assert property (
        (wd_state == SVWD_WD_RUN) && kick_fall && !wd_quiet |=> wd_count == '0)
        else $error("accepted kick did not restart counter");

    a_expiry_sets_flag: assert property (
        (wd_state == SVWD_WD_RUN) && !kick_fall && !wd_quiet
        && (wd_count == wd_limit - CNT_W'(1)) |=> !timeout_flag_n_oe_n)
        else $error("expiry did not assert timeout flag");

    a_flag_hold_time: assert property (
        $rose(timeout_flag_n) && !$past(wd_quiet)
        |-> $past(flag_count) == CNT_W'(RST_CYCLES - 1))
        else $error("timeout flag held for wrong time");

    a_flag_needs_reset_high: assert property (
        !timeout_flag_n_oe_n |-> sys_rst_n_oe_n)
        else $error("timeout flag low while reset low");

    a_select_limit: assert property (
        (sel_s == SEL_PULLUP) |-> wd_limit == CNT_W'(WD_STD_LIMIT))
        else $error("standard timeout not selected");

    c_reset_release: cover property ($rose(sys_rst_n_oe_n));
    c_timeout_flag: cover property ($fell(timeout_flag_n_oe_n));
    c_flag_release: cover property ($rose(timeout_flag_n) && sys_rst_n);
    c_kick_accepted: cover property ((wd_state == SVWD_WD_RUN) && kick_fall);

endmodule

// ---- test/svwd_host_model.sv ----
`timescale 1ns/100ps
module svwd_host_model (
    input  wire logic        sys_clk,
    input  wire logic        kick_enable,
    input  wire logic [7:0]  kick_period,
    output logic             kick_in
);
    // ------------------------------------------------------------------
    // Kick generator
    // ------------------------------------------------------------------
    // The kick line is always held at a firm level, even while kicking is
    // paused, because a floating kick pin would feed the watchdog random edges.
    logic [7:0] phase;

    initial begin
        kick_in = 1'h1;
        phase   = 8'h00;
    end

    always @(negedge sys_clk) begin
        if (!kick_enable) begin
            phase   <= 8'h00;
            kick_in <= 1'h1;
        end else if (phase == kick_period - 8'h01) begin
            phase   <= 8'h00;
            kick_in <= 1'h0;
        end else begin
            phase <= phase + 8'h01;
            if (phase == (kick_period >> 1)) begin
                kick_in <= 1'h1;
            end
        end
    end
endmodule

// ---- test/svwd_core_tb_top.sv ----
`timescale 1ns/100ps
module svwd_core_tb_top
    import svwd_pkg::*;
();
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    localparam int STD_LIM   = 50;
    localparam int EXT_LIM   = 100;
    localparam int CAP_LIM   = 30;
    localparam int CYC_LIMIT = 60000;

    logic        sys_clk;
    logic        resetn;
    logic        manual_rst_n;
    logic        manual_rst_float;
    logic        uv_detect;
    logic        wd_enable_strap;
    logic [1:0]  timeout_select_pin;
    logic        kick_in;
    logic        kick_enable;
    logic [7:0]  kick_period;
    logic        sys_rst_n_out;
    logic        sys_rst_n_oe_n;
    logic        timeout_flag_n_out;
    logic        timeout_flag_n_oe_n;
    logic        rst_pin;
    logic        flag_pin;
    int          fails;
    int          n_checks;
    int          cyc;

    // Both outputs are open drain with an outside pull-up.
    assign rst_pin  = sys_rst_n_oe_n ? 1'h1 : sys_rst_n_out;
    assign flag_pin = timeout_flag_n_oe_n ? 1'h1 : timeout_flag_n_out;

    svwd_core #(
        .WD_STD_LIMIT (STD_LIM),
        .WD_EXT_LIMIT (EXT_LIM),
        .WD_CAP_LIMIT (CAP_LIM)
    ) dut (
        .sys_clk             (sys_clk),
        .resetn              (resetn),
        .manual_rst_n        (manual_rst_n),
        .manual_rst_float    (manual_rst_float),
        .uv_detect           (uv_detect),
        .wd_enable_strap     (wd_enable_strap),
        .timeout_select_pin  (timeout_select_pin),
        .kick_in             (kick_in),
        .sys_rst_n_out       (sys_rst_n_out),
        .sys_rst_n_oe_n      (sys_rst_n_oe_n),
        .timeout_flag_n_out  (timeout_flag_n_out),
        .timeout_flag_n_oe_n (timeout_flag_n_oe_n)
    );

    svwd_host_model u_host (
        .sys_clk     (sys_clk),
        .kick_enable (kick_enable),
        .kick_period (kick_period),
        .kick_in     (kick_in)
    );

    initial begin
        sys_clk = 1'h0;
    end

    always #50 sys_clk = ~sys_clk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic seen, input logic exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic check_rng(input int n, input int lo, input int hi, input string msg);
        check(n >= lo && n <= hi, 1'h1, msg);
    endtask

    function automatic logic pin_of(input bit f);
        return f ? flag_pin : rst_pin;
    endfunction

    // Polls at falling edges, so every count is in whole clock cycles.
    task automatic wait_pin(input bit f, input logic v, input int max, output int n);
        n = 0;
        while (pin_of(f) !== v && n < max) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic flag_lows(input int cycles, output int lows);
        lows = 0;
        repeat (cycles) begin
            @(negedge sys_clk);
            if (flag_pin !== 1'h1) lows++;
        end
    endtask

    function automatic int lim_of(input logic [1:0] s);
        case (s)
            SEL_CAP:    return CAP_LIM;
            SEL_PULLUP: return STD_LIM;
            default:    return EXT_LIM;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_power_up();
        int n;
        repeat (8) @(negedge sys_clk);
        resetn = 1'h1;
        wait_pin(0, 1'h1, 2100, n);
        check_rng(n, RST_CYCLES, RST_CYCLES + 4, "power-up release delay");
    endtask

    // Kicks come slower than the standard limit, so a live watchdog would trip here.
    task automatic t_strap_off();
        int lows;
        kick_period = 8'h64;
        kick_enable = 1'h1;
        flag_lows(300, lows);
        check(lows == 0, 1'h1, "flag with watchdog disabled");
        kick_enable = 1'h0;
    endtask

    task automatic t_manual();
        int n;
        manual_rst_n     = 1'h0;
        manual_rst_float = 1'h1;
        repeat (20) begin
            @(negedge sys_clk);
            check(rst_pin, 1'h1, "undriven manual input caused reset");
        end
        manual_rst_float = 1'h0;
        wait_pin(0, 1'h0, 6, n);
        check_rng(n, 1, 4, "manual reset assert latency");
        repeat (5) @(negedge sys_clk);
        manual_rst_n = 1'h1;
        wait_pin(0, 1'h1, 2100, n);
        check_rng(n, RST_CYCLES, RST_CYCLES + 4, "manual reset release delay");
    endtask

    task automatic t_undervoltage();
        int n;
        uv_detect = 1'h1;
        wait_pin(0, 1'h0, 6, n);
        check_rng(n, 1, 4, "undervoltage assert latency");
        repeat (10) @(negedge sys_clk);
        uv_detect = 1'h0;
        wait_pin(0, 1'h1, 2100, n);
        check_rng(n, RST_CYCLES, RST_CYCLES + 4, "undervoltage release delay");
    endtask

    task automatic t_kicks();
        int lows;
        timeout_select_pin = SEL_PULLUP;
        kick_period        = 8'(STD_LIM - 5);
        wd_enable_strap    = 1'h1;
        kick_enable        = 1'h1;
        flag_lows(400, lows);
        check(lows == 0, 1'h1, "flag despite timely kicks");
        kick_enable = 1'h0;
    endtask

    task automatic t_timeouts();
        int n;
        int lim;
        for (int s = 0; s < 4; s++) begin
            timeout_select_pin = 2'(s);
            lim = lim_of(2'(s));
            wait_pin(1, 1'h0, lim + 2200, n);
            wait_pin(1, 1'h1, 2100, n);
            check_rng(n, RST_CYCLES - 1, RST_CYCLES + 1, "flag low length");
            wait_pin(1, 1'h0, lim + 10, n);
            check_rng(n, lim, lim + 3, "watchdog timeout length");
        end
    endtask

    // Starts just after the flag fell; fast kicks must not shorten the flag.
    task automatic t_kick_during_flag();
        int lows;
        kick_period = 8'h07;
        kick_enable = 1'h1;
        flag_lows(1990, lows);
        check(lows == 1990, 1'h1, "kick ended the timeout flag early");
        kick_enable = 1'h0;
    endtask

    task automatic t_reset_clears_flag();
        int n;
        int lows;
        manual_rst_n = 1'h0;
        wait_pin(0, 1'h0, 6, n);
        check(flag_pin, 1'h1, "flag kept low during reset");
        repeat (3) @(negedge sys_clk);
        manual_rst_n = 1'h1;
        lows = 0;
        n    = 0;
        while (rst_pin !== 1'h1 && n < 2100) begin
            if (flag_pin !== 1'h1) lows++;
            @(negedge sys_clk);
            n++;
        end
        check(lows == 0, 1'h1, "flag asserted while reset low");
        check(rst_pin, 1'h1, "reset not released after manual reset");
        wd_enable_strap = 1'h0;
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        fails              = 0;
        n_checks           = 0;
        cyc                = 0;
        resetn             = 1'h0;
        manual_rst_n       = 1'h1;
        manual_rst_float   = 1'h0;
        uv_detect          = 1'h0;
        wd_enable_strap    = 1'h0;
        timeout_select_pin = SEL_PULLUP;
        kick_enable        = 1'h0;
        kick_period        = 8'h07;
        t_power_up();
        t_strap_off();
        t_manual();
        t_undervoltage();
        t_kicks();
        t_timeouts();
        t_kick_during_flag();
        t_reset_clears_flag();
        finish_test();
    end
endmodule
